// ### posm_chk.sv
// Checker watching the ports of the pin source mux
`timescale 1ns/10ps
`default_nettype none
module posm_chk
  import posm_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        SRST,
  input wire logic        PIN_OUT,
  input wire logic        PIN_OE,
  input wire logic        FRAME_SYNC_SIGNAL,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic       wr_both;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  // Shadow of the control byte, both halves taken together
  assign wr_both = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
                   && S_AXI_WREADY;
  assign ctl_next = SRST ? 8'h00 : (wr_both && S_AXI_WSTRB[0]
                    && S_AXI_AWADDR == CTRL_ADDR) ? S_AXI_WDATA[7:0]
                    : ctl_reg;
  always_ff @(posedge MCLK)
    ctl_reg <= ctl_next;
  // Pin relations, and pin and bus answers quiet after reset
  off_low_a: assert property (!PIN_OE |-> !PIN_OUT)
    else $error("pin high while driver off");
  rst_quiet_a: assert property ($past(SRST) |-> !PIN_OE && !PIN_OUT
    && !S_AXI_BVALID && !S_AXI_RVALID) else $error("outputs busy after reset");
  oe_follow_a: assert property ($stable(ctl_reg)[*5]
    |-> PIN_OE == ctl_reg[0]) else $error("driver enable wrong");
  fsync_pass_a: assert property ($stable(ctl_reg)[*5] ##0
    (ctl_reg == 8'h91 && $stable(FRAME_SYNC_SIGNAL))
    |-> PIN_OUT == FRAME_SYNC_SIGNAL) else $error("frame sync not on pin");
  val_pass_a: assert property ($stable(ctl_reg)[*5] ##0
    (ctl_reg[7:2] == 6'h04 && ctl_reg[0]) |-> PIN_OUT == ctl_reg[1])
    else $error("held value not on pin");
  rsv_low_a: assert property ($stable(ctl_reg)[*5] ##0
    (ctl_reg[4:2] == 3'h5 || ctl_reg[4:2] == 3'h7) |-> !PIN_OUT)
    else $error("reserved source not low");
  // Bus relations
  wr_answer_a: assert property (wr_both |-> ##[1:3] S_AXI_BVALID)
    else $error("write not answered");
  bv_once_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write answer repeated");
  rv_once_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer repeated");
  ar_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
endmodule
bind posm_top posm_chk posm_chk_i (.*);
`default_nettype wire

// ### posm_pkg.sv
// Package: register map, field layout and carriers of the pin source mux
package posm_pkg;

  // Bus geometry
  localparam int          AXI_AW        = 8;
  localparam int          AXI_DW        = 32;

  // Register byte addresses and control register reset value
  localparam logic [7:0]  CTRL_ADDR     = 8'h14;
  localparam logic [7:0]  STAT_ADDR     = 8'h18;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Control register field positions
  localparam int          SEL_MSB       = 7;
  localparam int          SEL_LSB       = 5;
  localparam int          SRC_MSB       = 4;
  localparam int          SRC_LSB       = 2;
  localparam int          VAL_BIT       = 1;
  localparam int          EN_BIT        = 0;

  // Status register field positions
  localparam int          STAT_PIN_BIT  = 0;
  localparam int          STAT_OE_BIT   = 1;
  localparam int          STAT_RSV_BIT  = 2;

  // Source codes
  localparam logic [2:0]  SRC_RX0       = 3'h0;
  localparam logic [2:0]  SRC_RX1       = 3'h1;
  localparam logic [2:0]  SRC_RX2       = 3'h2;
  localparam logic [2:0]  SRC_RX3       = 3'h3;
  localparam logic [2:0]  SRC_DEV       = 3'h4;
  localparam logic [2:0]  SRC_TX0       = 3'h6;

  // Select codes, receive port source
  localparam logic [2:0]  RXS_PIN0      = 3'h0;
  localparam logic [2:0]  RXS_PIN1      = 3'h1;
  localparam logic [2:0]  RXS_PIN2      = 3'h2;
  localparam logic [2:0]  RXS_PIN3      = 3'h3;
  localparam logic [2:0]  RXS_LOCK      = 3'h4;
  localparam logic [2:0]  RXS_PASS      = 3'h5;
  localparam logic [2:0]  RXS_FV        = 3'h6;
  localparam logic [2:0]  RXS_LV        = 3'h7;

  // Select codes, device status source
  localparam logic [2:0]  DEV_VAL       = 3'h0;
  localparam logic [2:0]  DEV_LOCK_OR   = 3'h1;
  localparam logic [2:0]  DEV_LOCK_AND  = 3'h2;
  localparam logic [2:0]  DEV_PASS_AND  = 3'h3;
  localparam logic [2:0]  DEV_FSYNC     = 3'h4;

  // Select codes, transmit port source
  localparam logic [2:0]  TXS_PASS_AND  = 3'h0;
  localparam logic [2:0]  TXS_PASS_OR   = 3'h1;
  localparam logic [2:0]  TXS_FV        = 3'h2;
  localparam logic [2:0]  TXS_LV        = 3'h3;
  localparam logic [2:0]  TXS_SYNC      = 3'h4;
  localparam logic [2:0]  TXS_IRQ       = 3'h5;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // Signals of one receive port
  typedef struct packed {
    logic [3:0] rx_pins;
    logic       lock;
    logic       pass;
    logic       frame_valid;
    logic       line_valid;
  } posm_rx_t;

  // Signals of the transmit port
  typedef struct packed {
    logic       frame_valid;
    logic       line_valid;
    logic       synced;
    logic       irq;
  } posm_tx_t;

endpackage

// ### posm_top.sv
// Output source mux and driver gate of general_pin_four with AXI4-Lite regs
`timescale 1ns/10ps
`default_nettype none
module posm_top
  import posm_pkg::*;
#(
  parameter int NUM_RX = 4
)
(
  input  wire logic                             MCLK,
  input  wire logic                             SRST,
  input  wire posm_pkg::posm_rx_t [NUM_RX-1:0]  RX_STATUS,
  input  wire logic [NUM_RX-1:0]                RX_PORT_ENABLE,
  input  wire logic [NUM_RX-1:0]                TX_PORT_SELECT,
  input  wire posm_pkg::posm_tx_t               TX_STATUS,
  input  wire logic                             FRAME_SYNC_SIGNAL,
  output logic                                  PIN_OUT,
  output logic                                  PIN_OE,
  input  wire logic [posm_pkg::AXI_AW-1:0]      S_AXI_AWADDR,
  input  wire logic                             S_AXI_AWVALID,
  output logic                                  S_AXI_AWREADY,
  input  wire logic [posm_pkg::AXI_DW-1:0]      S_AXI_WDATA,
  input  wire logic [3:0]                       S_AXI_WSTRB,
  input  wire logic                             S_AXI_WVALID,
  output logic                                  S_AXI_WREADY,
  output logic [1:0]                            S_AXI_BRESP,
  output logic                                  S_AXI_BVALID,
  input  wire logic                             S_AXI_BREADY,
  input  wire logic [posm_pkg::AXI_AW-1:0]      S_AXI_ARADDR,
  input  wire logic                             S_AXI_ARVALID,
  output logic                                  S_AXI_ARREADY,
  output logic [posm_pkg::AXI_DW-1:0]           S_AXI_RDATA,
  output logic [1:0]                            S_AXI_RRESP,
  output logic                                  S_AXI_RVALID,
  input  wire logic                             S_AXI_RREADY
);

  import posm_pkg::*;

  // Receive port signals come from link domains: two-flop synchroniser
  posm_rx_t [NUM_RX-1:0] rx_meta_reg;
  posm_rx_t [NUM_RX-1:0] rx_sync_reg;

  // Register file and pin state
  logic [7:0]            ctrl_reg;
  logic [7:0]            ctrl_next;
  logic                  pin_reg;
  logic                  pin_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic                  rsv_reg;
  logic                  rsv_next;

  // Bus slave state
  logic                  aw_got_reg;
  logic                  aw_got_next;
  logic                  w_got_reg;
  logic                  w_got_next;
  logic [AXI_AW-1:0]     awaddr_reg;
  logic [AXI_AW-1:0]     awaddr_next;
  logic [7:0]            wbyte_reg;
  logic [7:0]            wbyte_next;
  logic                  wstrb0_reg;
  logic                  wstrb0_next;
  logic                  bvalid_reg;
  logic                  bvalid_next;
  logic [1:0]            bresp_reg;
  logic [1:0]            bresp_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [AXI_DW-1:0]     rdata_reg;
  logic [AXI_DW-1:0]     rdata_next;
  logic [1:0]            rresp_reg;
  logic [1:0]            rresp_next;
  logic                  awready_reg;
  logic                  awready_next;
  logic                  wready_reg;
  logic                  wready_next;
  logic                  arready_reg;
  logic                  arready_next;

  // Per-port flag vectors gathered from the synchronised status
  logic [NUM_RX-1:0]     lock_vec;
  logic [NUM_RX-1:0]     pass_vec;

  // Decoded control fields and word-aligned bus addresses
  logic [2:0]            sel;
  logic [2:0]            src;
  logic [1:0]            port;
  logic [AXI_AW-1:0]     aw_word;
  logic [AXI_AW-1:0]     ar_word;

  assign sel     = ctrl_reg[SEL_MSB:SEL_LSB];
  assign src     = ctrl_reg[SRC_MSB:SRC_LSB];
  assign port    = src[1:0];
  assign aw_word = {awaddr_reg[AXI_AW-1:2], 2'h0};
  assign ar_word = {S_AXI_ARADDR[AXI_AW-1:2], 2'h0};

  // Flag vectors, one bit per receive port
  for (genvar i = 0; i < NUM_RX; i++)
  begin : g_flags
    assign lock_vec[i] = rx_sync_reg[i].lock;
    assign pass_vec[i] = rx_sync_reg[i].pass;
  end

  // Synchroniser stages; first stage feeds only the second
  always_ff @(posedge MCLK)
  begin
    rx_meta_reg <= RX_STATUS;
    rx_sync_reg <= rx_meta_reg;
  end

  // Source and select decode for the pin
  always_comb
  begin
    pin_next = 1'b0;
    rsv_next = 1'b0;
    case (src)
      SRC_RX0, SRC_RX1, SRC_RX2, SRC_RX3:
      begin
        case (sel)
          RXS_PIN0, RXS_PIN1, RXS_PIN2, RXS_PIN3:
            pin_next = rx_sync_reg[port].rx_pins[sel[1:0]];
          RXS_LOCK: pin_next = rx_sync_reg[port].lock;
          RXS_PASS: pin_next = rx_sync_reg[port].pass;
          RXS_FV:   pin_next = rx_sync_reg[port].frame_valid;
          RXS_LV:   pin_next = rx_sync_reg[port].line_valid;
          default:  pin_next = 1'b0;
        endcase
      end
      SRC_DEV:
      begin
        case (sel)
          DEV_VAL:      pin_next = ctrl_reg[VAL_BIT];
          DEV_LOCK_OR:  pin_next = |(lock_vec & RX_PORT_ENABLE);
          DEV_LOCK_AND: pin_next = &(lock_vec | ~RX_PORT_ENABLE);
          DEV_PASS_AND: pin_next = &(pass_vec | ~RX_PORT_ENABLE);
          DEV_FSYNC:    pin_next = FRAME_SYNC_SIGNAL;
          default:
          begin
            pin_next = 1'b0;
            rsv_next = 1'b1;
          end
        endcase
      end
      SRC_TX0:
      begin
        case (sel)
          TXS_PASS_AND: pin_next = &(pass_vec | ~TX_PORT_SELECT);
          TXS_PASS_OR:  pin_next = |(pass_vec & TX_PORT_SELECT);
          TXS_FV:       pin_next = TX_STATUS.frame_valid;
          TXS_LV:       pin_next = TX_STATUS.line_valid;
          TXS_SYNC:     pin_next = TX_STATUS.synced;
          TXS_IRQ:      pin_next = TX_STATUS.irq;
          default:
          begin
            pin_next = 1'b0;
            rsv_next = 1'b1;
          end
        endcase
      end
      default:
      begin
        pin_next = 1'b0;
        rsv_next = 1'b1;
      end
    endcase
    oe_next = ctrl_reg[EN_BIT];
    if (!ctrl_reg[EN_BIT])
    begin
      pin_next = 1'b0;
    end
  end

  // Bus slave: write and read channels, register write
  always_comb
  begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awaddr_next = awaddr_reg;
    wbyte_next  = wbyte_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    ctrl_next   = ctrl_reg;
    // Address and data taken in either order
    if (S_AXI_AWVALID && !aw_got_reg && !bvalid_reg)
    begin
      aw_got_next = 1'b1;
      awaddr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_got_reg && !bvalid_reg)
    begin
      w_got_next  = 1'b1;
      wbyte_next  = S_AXI_WDATA[7:0];
      wstrb0_next = S_AXI_WSTRB[0];
    end
    // Both halves held: perform write and raise response
    if (aw_got_reg && w_got_reg && !bvalid_reg)
    begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = RESP_OKAY;
      if (aw_word == CTRL_ADDR)
      begin
        if (wstrb0_reg)
        begin
          ctrl_next = wbyte_reg;
        end
      end
      else if (aw_word != STAT_ADDR)
      begin
        bresp_next = RESP_DECERR;
      end
    end
    if (bvalid_reg && S_AXI_BREADY)
    begin
      bvalid_next = 1'b0;
    end
    // Read: answer the cycle after the address is taken
    if (S_AXI_ARVALID && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = RESP_OKAY;
      if (ar_word == CTRL_ADDR)
      begin
        rdata_next[7:0] = ctrl_reg;
      end
      else if (ar_word == STAT_ADDR)
      begin
        rdata_next[STAT_PIN_BIT] = pin_reg;
        rdata_next[STAT_OE_BIT]  = oe_reg;
        rdata_next[STAT_RSV_BIT] = rsv_reg;
      end
      else
      begin
        rresp_next = RESP_DECERR;
      end
    end
    else if (rvalid_reg && S_AXI_RREADY)
    begin
      rvalid_next = 1'b0;
    end
    // Ready flags registered from the next channel state
    awready_next = !aw_got_next && !bvalid_next;
    wready_next  = !w_got_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  // State registers; synchronous reset to constants
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      ctrl_reg   <= CTRL_RESET;
      pin_reg    <= 1'b0;
      oe_reg     <= 1'b0;
      rsv_reg    <= 1'b0;
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wbyte_reg  <= '0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      arready_reg <= 1'b1;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      pin_reg    <= pin_next;
      oe_reg     <= oe_next;
      rsv_reg    <= rsv_next;
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awaddr_reg <= awaddr_next;
      wbyte_reg  <= wbyte_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      arready_reg <= arready_next;
    end
  end

  // Outputs straight from flip-flops
  assign PIN_OUT       = pin_reg;
  assign PIN_OE        = oe_reg;
  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY  = wready_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign S_AXI_RRESP   = rresp_reg;

endmodule
`default_nettype wire

// ### posm_top_tb.sv
// Self-checking bench of the pin source mux
`timescale 1ns/10ps
`default_nettype none
module posm_top_tb;
  import posm_pkg::*;
  logic           clk, rst, fs, pin, oe;
  posm_rx_t [3:0] rxs;
  posm_tx_t       txst;
  logic [3:0]     rxe, txs, ws;
  logic [7:0]     awa, ara, c;
  logic [31:0]    wd, rd;
  logic [1:0]     br, rr;
  logic           awv, awr, wv, wr, bv, bre, arv, arr, rv, rre;
  logic [36:0]    mon_e;
  logic [36:0]    exp_q[$];
  int             num_errors, comparisons;
  posm_top posm_top_i (
    .MCLK(clk), .SRST(rst), .RX_STATUS(rxs), .RX_PORT_ENABLE(rxe),
    .TX_PORT_SELECT(txs), .TX_STATUS(txst), .FRAME_SYNC_SIGNAL(fs),
    .PIN_OUT(pin), .PIN_OE(oe), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre));
  // Clock of 40 ns
  always #20 clk = ~clk;
  task automatic check(input string what, input logic [33:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  // Compare of the driver enable and pin level pair
  task automatic check_pin(input logic [1:0] e, s);
    comparisons++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED pin levels expected %h seen %h", e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One bus transfer; note holds pin flag, pin levels, response, data
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [36:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    if (w)
    begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
    end
    else
    begin
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
      if (arr)
        arv <= 1'b0;
      n++;
    end
    while (!(bv && bre) && !(rv && rre) && n < 50);
    bre <= 1'b0;
    rre <= 1'b0;
    if (n >= 50)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // Expected pin level for a control byte and the present inputs
  function automatic logic exp_pin(input logic [7:0] k);
    logic [3:0] lk, ps;
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      lk[i] = rxs[i].lock;
      ps[i] = rxs[i].pass;
    end
    case (k[4:2])
      3'h4: v = {3'h0, fs, &(ps | ~rxe), &(lk | ~rxe), |(lk & rxe), k[1]};
      3'h6: v = {2'h0, txst.irq, txst.synced, txst.line_valid,
                 txst.frame_valid, |(ps & txs), &(ps | ~txs)};
      3'h5, 3'h7: v = 8'h00;
      default: v = {rxs[k[3:2]].line_valid, rxs[k[3:2]].frame_valid,
                    rxs[k[3:2]].pass, rxs[k[3:2]].lock, rxs[k[3:2]].rx_pins};
    endcase
    return k[0] & v[k[7:5]];
  endfunction
  function automatic logic rsv(input logic [7:0] k);
    return k[4:2] == 3'h5 || k[4:2] == 3'h7
           || (k[4:2] == 3'h4 && k[7:5] > 3'h4)
           || (k[4:2] == 3'h6 && k[7:5] > 3'h5);
  endfunction
  // Takes the oldest note as each answer appears
  always @(posedge clk)
  begin
    if ((bv && bre) || (rv && rre))
    begin
      mon_e = exp_q.pop_front();
      check(bv ? "write answer" : "read answer", mon_e[33:0],
            bv ? {br, 32'h0} : {rr, rd});
      if (mon_e[36])
        check_pin(mon_e[35:34], {oe, pin});
    end
  end
  initial
  begin
    {clk, fs, awv, wv, bre, arv, rre, rxe, txs, rxs, txst} = '0;
    {awa, ara, wd, c} = '0;
    ws = 4'hF;
    rst = 1'b1;
    void'($urandom(22002));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, CTRL_ADDR, 32'h0, {3'h4, RESP_OKAY, 32'h0});
    bus(1'b0, 8'h20, 32'h0, {3'h0, RESP_DECERR, 32'h0});
    bus(1'b1, 8'h20, 32'h5A, {3'h0, RESP_DECERR, 32'h0});
    $display("test reset and decode done");
    // Every control byte, random pin sources
    for (int i = 0; i < 256; i++)
    begin
      c = i[7:0];
      @(posedge clk);
      rxs <= $urandom;
      txst <= 4'($urandom);
      rxe <= 4'($urandom);
      txs <= 4'($urandom);
      fs <= 1'($urandom);
      bus(1'b1, CTRL_ADDR, {24'($urandom), c}, {3'h0, RESP_OKAY, 32'h0});
      repeat (4) @(posedge clk);
      bus(1'b0, CTRL_ADDR, 32'h0, {3'h0, RESP_OKAY, 24'h0, c});
      bus(1'b0, STAT_ADDR, 32'h0, {1'b1, c[0], exp_pin(c), RESP_OKAY,
          29'h0, rsv(c), c[0], exp_pin(c)});
    end
    $display("test code sweep done");
    // Byte lane 0 off leaves control unchanged
    ws <= 4'hE;
    bus(1'b1, CTRL_ADDR, 32'h0, {3'h0, RESP_OKAY, 32'h0});
    bus(1'b1, STAT_ADDR, 32'h0, {3'h0, RESP_OKAY, 32'h0});
    bus(1'b0, CTRL_ADDR, 32'h0, {3'h6, RESP_OKAY, 32'hFF});
    $display("test strobe done");
    report_and_stop();
  end
endmodule
`default_nettype wire
